// ---- host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Host side: drives the standby and input pins, register writes and command pulses.
module host_model (
   input  wire logic       clk,
   output var  logic       standby_pin,
   output var  logic [1:0] direct_input_pin,
   output var  logic       spi_wr,
   output var  logic [7:0] spi_out_en,
   output var  logic [7:0] spi_map0,
   output var  logic [7:0] spi_map1,
   output var  logic       spi_hold,
   output var  logic       spi_cmd_done,
   output var  logic       soft_reset_bit
);
   // Control lines idle low; released data lines never show a valid value.
   initial {standby_pin, direct_input_pin, spi_wr, spi_hold, spi_cmd_done, soft_reset_bit} = 0;
   initial {spi_out_en, spi_map0, spi_map1} = 24'h5A5A5A;
   // Sets both pin levels just after a falling edge.
   task pins(input logic s, input logic [1:0] i);
      @(negedge clk);
      standby_pin = s;
      direct_input_pin = i;
   endtask
   // One write cycle, issued at the next falling edge whatever the mode.
   task wr(input logic [7:0] oe, m0, m1, input logic h);
      @(negedge clk);
      {spi_wr, spi_out_en, spi_map0, spi_map1, spi_hold} = {1'b1, oe, m0, m1, h};
      @(negedge clk);
      {spi_wr, spi_out_en, spi_map0, spi_map1, spi_hold} = {1'b0, ~oe, ~m0, ~m1, ~h};
   endtask
   // One-cycle pulse: soft reset when sr is set, end of command otherwise.
   task pulse(input logic sr);
      @(negedge clk);
      soft_reset_bit = sr;
      spi_cmd_done = !sr;
      @(negedge clk);
      {soft_reset_bit, spi_cmd_done} = 2'b00;
   endtask
endmodule // host_model
`default_nettype wire

// ---- limp_status.v ----
`timescale 1ns/1ns
`default_nettype none

// Overrides of read-back status while in limp home.
module limp_status (
   input  wire       clk,
   input  wire       rst_b,
   input  wire       limp,
   input  wire       spi_cmd_done,
   input  wire       uv_raw,
   input  wire       lop_raw,
   input  wire       ter_raw,
   input  wire       open_load_on_flag_raw,
   input  wire       open_load_off_flag_raw,
   output reg        analog_undervoltage_flag,
   output reg        digital_low_power_flag,
   output reg        transmission_error_flag,
   output reg        open_load_on_flag,
   output reg        open_load_off_flag
);

   reg limp_d_ff;
   reg ter_force_ff;
   wire nxt_ter_force;

   // Forced error flag is armed on limp entry and consumed by the first command.
   assign nxt_ter_force = (limp && !limp_d_ff) ? 1'b1 :
                          (spi_cmd_done || !limp) ? 1'b0 : ter_force_ff;

   // Registered flag outputs with limp-home overrides.
   always @(posedge clk) begin
      if (!rst_b) begin
         limp_d_ff                <= 1'b0;
         ter_force_ff             <= 1'b0;
         analog_undervoltage_flag <= 1'b0;
         digital_low_power_flag   <= 1'b0;
         transmission_error_flag  <= 1'b0;
         open_load_on_flag        <= 1'b0;
         open_load_off_flag       <= 1'b0;
      end else begin
         limp_d_ff                <= limp;
         ter_force_ff             <= nxt_ter_force;
         analog_undervoltage_flag <= limp | uv_raw;
         digital_low_power_flag   <= limp | lop_raw;
         transmission_error_flag  <= nxt_ter_force | ter_raw;
         open_load_on_flag        <= !limp & open_load_on_flag_raw;
         open_load_off_flag       <= !limp & open_load_off_flag_raw;
      end
   end

endmodule // limp_status

`default_nettype wire

// ---- operation_mode_controller.v ----
// Functional notes
// - Four modes: sleep, idle, active, limp home.
// - Transitions use standby, inputs, enables, hold, generators.
// - Switch-on request enters active or limp home.
// - Power-up needs supply plus input or standby.
// - Power-on from analog or digital supply threshold.
// - Sleep: outputs off, registers held reset.
// - Idle: outputs off, diagnostics disabled.
// - Idle with digital supply: SPI works.
// - Idle keeps latched channel error bits.
// - Active when standby high and request present.
// - Without hold, no request returns to idle.
// - Hold bit keeps active mode.
// - Digital undervoltage with inputs low gives idle.
// - High input forces active despite empty maps.
// - Standby low, input high enters limp home.
// - Limp home: SPI reads only, writes ignored.
// - Limp home: supply flags read one.
// - Limp home: mode status reads 01.
// - First command after limp entry flags error.
// - Limp home: open-load flags read zero.
// - Limp home: other registers default, locked.
// - Limp home: only channels 2 and 3.
// - Registers reset on supply loss, standby, command.
// - Soft reset keeps error bits, clears supply flags.
`include "opmode_map.vh"
`timescale 1ns/1ns
`default_nettype none

module operation_mode_controller #(
   parameter NCH      = 8,
   parameter SETTLE   = `MODE_SETTLE_CYC
) (
   input  wire           clk,
   input  wire           rst_b,
   input  wire           standby_pin,
   input  wire [1:0]     direct_input_pin,
   input  wire           vs_present,
   input  wire           vdd_present,
   input  wire           vs_above_op,
   input  wire           vdd_above_lop,
   input  wire           vdd_uv,
   input  wire           spi_wr,
   input  wire [NCH-1:0] spi_out_en,
   input  wire [NCH-1:0] spi_map0,
   input  wire [NCH-1:0] spi_map1,
   input  wire           spi_hold,
   input  wire           spi_pg0,
   input  wire           spi_pg1,
   input  wire           soft_reset_bit,
   input  wire           spi_cmd_done,
   input  wire [NCH-1:0] chan_fault,
   input  wire           uv_raw,
   input  wire           lop_raw,
   input  wire           ter_raw,
   input  wire           open_load_on_flag_raw,
   input  wire           open_load_off_flag_raw,
   output reg  [1:0]     mode_ff,
   output wire [1:0]     mode_status,
   output reg  [NCH-1:0] chan_on_ff,
   output reg  [NCH-1:0] output_enable_bit,
   output reg  [NCH-1:0] input0_channel_map,
   output reg  [NCH-1:0] input1_channel_map,
   output reg            hold_active_bit,
   output reg            pulse_gen0_enable,
   output reg            pulse_gen1_enable,
   output reg  [NCH-1:0] channel_error_bit,
   output wire           regs_in_reset,
   output wire           spi_usable,
   output wire           spi_write_ok,
   output wire           diag_enable,
   output wire           power_on,
   output wire           analog_undervoltage_flag,
   output wire           digital_low_power_flag,
   output wire           transmission_error_flag,
   output wire           open_load_on_flag,
   output wire           open_load_off_flag
);

   // Width of the transition-latency counter.
   localparam CW = 8;

   wire       standby_s;
   wire [1:0] in_s;
   reg  [1:0] nxt_mode;
   reg  [CW-1:0] settle_ff;
   wire       any_in;
   wire       any_req;
   wire       powered;
   wire       reg_clear;

   // Standby and input pins are asynchronous levels.
   pin_sync #(.W(3)) u_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in ({standby_pin, direct_input_pin}),
      .sync_out ({standby_s, in_s})
   );

   // Requests: pins, enable bits, or running pulse generators.
   assign any_in  = |in_s;
   assign any_req = any_in | (|output_enable_bit) | pulse_gen0_enable | pulse_gen1_enable;

   // Power-on indication and power-up condition.
   assign power_on = vs_above_op | vdd_above_lop;
   assign powered  = (vs_present | vdd_present) & (any_in | standby_s);

   // Mode transition decision.
   always @* begin
      nxt_mode = mode_ff;
      if (!powered) begin
         nxt_mode = `MODE_SLEEP;
      end else begin
         case (mode_ff)
            `MODE_SLEEP, `MODE_IDLE: begin
               if (!standby_s && any_in)
                  nxt_mode = `MODE_LIMP;
               else if (standby_s && (any_in || (any_req && !vdd_uv)))
                  nxt_mode = `MODE_ACTIVE;
               else if (standby_s)
                  nxt_mode = `MODE_IDLE;
               else
                  nxt_mode = `MODE_SLEEP;
            end
            `MODE_ACTIVE: begin
               if (!standby_s)
                  nxt_mode = any_in ? `MODE_LIMP : `MODE_SLEEP;
               else if (vdd_uv && !any_in)
                  nxt_mode = `MODE_IDLE;
               else if (!hold_active_bit && !any_req)
                  nxt_mode = `MODE_IDLE;
            end
            `MODE_LIMP: begin
               if (standby_s)
                  nxt_mode = any_req ? `MODE_ACTIVE : `MODE_IDLE;
               else if (!any_in)
                  nxt_mode = `MODE_SLEEP;
            end
            default: nxt_mode = `MODE_SLEEP;
         endcase
      end
   end

   // Mode register with transition latency before channels may turn on.
   always @(posedge clk) begin
      if (!rst_b) begin
         mode_ff   <= `MODE_SLEEP;
         settle_ff <= {CW{1'b0}};
      end else begin
         mode_ff <= nxt_mode;
         if (nxt_mode != mode_ff)
            settle_ff <= SETTLE[CW-1:0];
         else if (settle_ff != {CW{1'b0}})
            settle_ff <= settle_ff - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // Mode-dependent access qualifiers.
   assign mode_status   = mode_ff;
   assign regs_in_reset = (mode_ff == `MODE_SLEEP) | !vdd_present | vdd_uv
                          | !standby_s;
   assign reg_clear     = regs_in_reset | soft_reset_bit;
   assign spi_usable    = (mode_ff != `MODE_SLEEP) & vdd_present & !vdd_uv;
   assign spi_write_ok  = spi_usable & (mode_ff != `MODE_LIMP);
   assign diag_enable   = (mode_ff == `MODE_ACTIVE);

   // Control registers; limp home holds defaults and refuses writes.
   always @(posedge clk) begin
      if (!rst_b || reg_clear || mode_ff == `MODE_LIMP) begin
         output_enable_bit  <= `OUT_EN_RESET;
         input0_channel_map <= `MAP0_RESET;
         input1_channel_map <= `MAP1_RESET;
         hold_active_bit    <= 1'b0;
         pulse_gen0_enable  <= 1'b0;
         pulse_gen1_enable  <= 1'b0;
      end else if (spi_wr && spi_write_ok) begin
         output_enable_bit  <= spi_out_en;
         input0_channel_map <= spi_map0;
         input1_channel_map <= spi_map1;
         hold_active_bit    <= spi_hold;
         pulse_gen0_enable  <= spi_pg0;
         pulse_gen1_enable  <= spi_pg1;
      end
   end

   // Latched error bits survive idle, limp home and soft reset; clear wins.
   // Limp home runs with standby low, so only sleep or a digital supply fault clears them.
   always @(posedge clk) begin
      if (!rst_b || mode_ff == `MODE_SLEEP || !vdd_present || vdd_uv) begin
         channel_error_bit <= {NCH{1'b0}};
      end else begin
         channel_error_bit <= channel_error_bit | chan_fault;
      end
   end

   // Channel drive per mode.
   always @(posedge clk) begin
      if (!rst_b) begin
         chan_on_ff <= {NCH{1'b0}};
      end else if (settle_ff != {CW{1'b0}}) begin
         chan_on_ff <= {NCH{1'b0}};
      end else begin
         case (mode_ff)
            `MODE_ACTIVE:
               chan_on_ff <= output_enable_bit
                             | ({NCH{in_s[0]}} & input0_channel_map)
                             | ({NCH{in_s[1]}} & input1_channel_map);
            `MODE_LIMP:
               chan_on_ff <= {{(NCH-4){1'b0}}, in_s[1], in_s[0], 2'b00}
                             & `LIMP_CH_MASK;
            default: chan_on_ff <= {NCH{1'b0}};
         endcase
      end
   end

   // Status flags with limp-home overrides; soft reset clears supply flags.
   limp_status u_limp (
      .clk                      (clk),
      .rst_b                    (rst_b),
      .limp                     (mode_ff == `MODE_LIMP),
      .spi_cmd_done             (spi_cmd_done),
      .uv_raw                   (uv_raw & !soft_reset_bit),
      .lop_raw                  (lop_raw & !soft_reset_bit),
      .ter_raw                  (ter_raw),
      .open_load_on_flag_raw                 (open_load_on_flag_raw & diag_enable),
      .open_load_off_flag_raw                (open_load_off_flag_raw & diag_enable),
      .analog_undervoltage_flag (analog_undervoltage_flag),
      .digital_low_power_flag   (digital_low_power_flag),
      .transmission_error_flag  (transmission_error_flag),
      .open_load_on_flag        (open_load_on_flag),
      .open_load_off_flag       (open_load_off_flag)
   );

endmodule // operation_mode_controller

`default_nettype wire

// ---- opmode_map.vh ----
`ifndef OPMODE_MAP_VH
`define OPMODE_MAP_VH

// Operation-mode encodings; the limp-home code is also the mode status field value.
`define MODE_SLEEP        2'h0
`define MODE_LIMP         2'h1
`define MODE_IDLE         2'h2
`define MODE_ACTIVE       2'h3

// Default values of the input-to-channel mapping registers.
`define MAP0_RESET        8'h04
`define MAP1_RESET        8'h08

// Channels that the inputs may drive while in limp home.
`define LIMP_CH_MASK      8'h0C

// Default of the output-enable register.
`define OUT_EN_RESET      8'h00

// Mode transition latency, in ns, and its cycle count at 100 MHz.
`define MODE_SETTLE_NS    100
`define CLK_PERIOD_NS     10
`define MODE_SETTLE_CYC   ((`MODE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- opmode_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "opmode_map.vh"
// Watches the controller ports for mode, channel and limp-home behaviour.
module opmode_sva #(
   parameter NCH    = 8,
   parameter SETTLE = 10
) (
   input wire logic           clk,
   input wire logic           rst_b,
   input wire logic           standby_pin,
   input wire logic [1:0]     direct_input_pin,
   input wire logic [1:0]     mode_ff,
   input wire logic [1:0]     mode_status,
   input wire logic [NCH-1:0] chan_on_ff,
   input wire logic [NCH-1:0] output_enable_bit,
   input wire logic           hold_active_bit,
   input wire logic           pulse_gen0_enable,
   input wire logic           pulse_gen1_enable,
   input wire logic           spi_write_ok,
   input wire logic           diag_enable,
   input wire logic           analog_undervoltage_flag,
   input wire logic           digital_low_power_flag,
   input wire logic           transmission_error_flag,
   input wire logic           open_load_on_flag,
   input wire logic           open_load_off_flag
);
   // Pins pass two sync stages, so mode checks wait four samples of steady pins.
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_sleep_dark: assert property
      ((mode_ff == `MODE_SLEEP) [*2] |-> chan_on_ff == 0) else $error("channel on in sleep");
   a_idle_quiet: assert property
      ((mode_ff == `MODE_IDLE) [*2] |-> chan_on_ff == 0 && !diag_enable) else $error("idle busy");
   a_enter_active: assert property
      ((standby_pin && direct_input_pin != 0) [*4] |-> mode_ff == `MODE_ACTIVE)
      else $error("no active entry");
   a_back_idle: assert property
      ((standby_pin && direct_input_pin == 0 && output_enable_bit == 0 && !hold_active_bit &&
      !pulse_gen0_enable && !pulse_gen1_enable) [*4]
      |-> mode_ff == `MODE_IDLE) else $error("no idle return");
   a_hold_keep: assert property
      ((mode_ff == `MODE_ACTIVE && hold_active_bit && standby_pin) [*3] |=>
      mode_ff == `MODE_ACTIVE) else $error("hold lost active");
   a_enter_limp: assert property
      ((!standby_pin && direct_input_pin != 0) [*4] |-> mode_ff == `MODE_LIMP)
      else $error("no limp entry");
   a_limp_locked: assert property
      ((mode_ff == `MODE_LIMP) [*2] |-> !spi_write_ok && output_enable_bit == 0 &&
      !hold_active_bit) else $error("limp registers open");
   a_limp_flags: assert property
      ((mode_ff == `MODE_LIMP) [*2] |-> mode_status == 2'b01 && analog_undervoltage_flag &&
      digital_low_power_flag && !open_load_on_flag && !open_load_off_flag)
      else $error("limp flags wrong");
   a_limp_ter: assert property
      (mode_ff == `MODE_LIMP && $past(mode_ff) != `MODE_LIMP |=> transmission_error_flag)
      else $error("no error flag on limp entry");
   a_limp_pair: assert property
      ((mode_ff == `MODE_LIMP) [*2] |-> (chan_on_ff & ~`LIMP_CH_MASK) == 0)
      else $error("limp drives other channel");
   c_active: cover property (mode_ff == `MODE_ACTIVE && chan_on_ff != 0);
   c_limp: cover property (mode_ff == `MODE_LIMP && chan_on_ff != 0);
   c_hold: cover property (mode_ff == `MODE_ACTIVE && hold_active_bit && output_enable_bit == 0);
   c_pulse: cover property (mode_ff == `MODE_ACTIVE && (pulse_gen0_enable || pulse_gen1_enable));
endmodule // opmode_sva
bind operation_mode_controller opmode_sva #(.NCH(NCH), .SETTLE(SETTLE)) opmode_sva_i (.*);
`default_nettype wire

// ---- pin_sync.v ----
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for a bus of asynchronous pin levels.
module pin_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_b,
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   // First stage feeds only the second stage.
   always @(posedge clk) begin
      if (!rst_b) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule // pin_sync

`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "opmode_map.vh"
module tb_top;
   logic        clk, rst_b, vdd_above_lop, vdd_uv, uv_raw, lop_raw, ter_raw, open_load_on_flag_raw, open_load_off_flag_raw;
   logic        vs_present = 1, vdd_present = 1, vs_above_op = 1, spi_pg0 = 0, spi_pg1 = 0;
   logic [7:0]  chan_fault, oe_m, m0_m, m1_m;
   logic [1:0]  mode_m, in_m;
   logic        s_m, h_m, g_m;
   logic [16:0] rnd = 17'h13ECC;
   int          err_count = 0, compares = 0;
   wire         standby_pin, spi_wr, spi_hold, spi_cmd_done, soft_reset_bit, hold_active_bit;
   wire         pulse_gen0_enable, pulse_gen1_enable, regs_in_reset, spi_usable, spi_write_ok;
   wire         diag_enable, power_on, analog_undervoltage_flag, digital_low_power_flag;
   wire         transmission_error_flag, open_load_on_flag, open_load_off_flag;
   wire [1:0]   direct_input_pin, mode_ff, mode_status;
   wire [7:0]   spi_out_en, spi_map0, spi_map1, chan_on_ff, output_enable_bit, channel_error_bit;
   wire [7:0]   input0_channel_map, input1_channel_map;
   host_model host_model_i (.*);
   operation_mode_controller operation_mode_controller_i (.*);
   // Free-running 100 MHz clock.
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   function automatic logic [16:0] lfsr(input logic [16:0] v);
      lfsr = {v[15:0], v[16] ^ v[13]};
   endfunction
   task chk_mode(input logic [1:0] exp);
      compares++;
      if (mode_ff !== exp) begin
         err_count++;
         $display("ERROR %0t mode %h expected %h", $time, mode_ff, exp);
      end
   endtask
   task chk_val(input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask
   // Reference step: reset registers, pick the mode, wait out the settle, compare.
   task settle;
      if (!s_m || vdd_uv) {oe_m, h_m, g_m, m0_m, m1_m} = {8'h00, 2'b00, 8'h04, 8'h08};
      if (!s_m) mode_m = in_m ? `MODE_LIMP : `MODE_SLEEP;
      else mode_m = (in_m || oe_m || g_m || h_m && mode_m == `MODE_ACTIVE) ?
         `MODE_ACTIVE : `MODE_IDLE;
      repeat (16) @(negedge clk);
      chk_mode(mode_m);
      chk_val(output_enable_bit, oe_m);
      chk_val(chan_on_ff, mode_m == `MODE_LIMP ? {4'h0, in_m, 2'b00} :
         mode_m != `MODE_ACTIVE ? 8'h00 : oe_m | {8{in_m[0]}} & m0_m | {8{in_m[1]}} & m1_m);
      chk_val({2'b00, mode_status, analog_undervoltage_flag, digital_low_power_flag,
         open_load_on_flag, open_load_off_flag}, mode_m == `MODE_LIMP ? 8'h1C :
         {2'b00, mode_m, uv_raw, lop_raw, {2{mode_m == `MODE_ACTIVE}} & {open_load_on_flag_raw, open_load_off_flag_raw}});
      chk_val({4'h0, regs_in_reset, spi_usable, spi_write_ok, power_on}, {4'h0,
         mode_m == `MODE_SLEEP || vdd_uv || !s_m, mode_m != `MODE_SLEEP && !vdd_uv,
         mode_m[1] && !vdd_uv, vs_above_op || vdd_above_lop});
   endtask
   task pins(input logic s, input logic [1:0] i);
      host_model_i.pins(s, i);
      {s_m, in_m} = {s, i};
      settle;
   endtask
   task write(input logic [7:0] oe, m0, m1, input logic h);
      host_model_i.wr(oe, m0, m1, h);
      if (mode_m[1] && !vdd_uv)
         {oe_m, m0_m, m1_m, h_m, g_m} = {oe, m0, m1, h, spi_pg0 || spi_pg1};
      settle;
   endtask
   task print_verdict;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      print_verdict;
   end
   // Main sequence: idle, active, hold, empty maps, undervoltage, soft reset, limp, random pins.
   initial begin
      {rst_b, vdd_above_lop, vdd_uv, uv_raw, lop_raw, ter_raw, open_load_on_flag_raw, open_load_off_flag_raw, g_m} = 0;
      {chan_fault, s_m, h_m, in_m, oe_m, m0_m, m1_m, mode_m} = {8'h00, 4'h0, 24'h000408, 2'h0};
      repeat (2) @(negedge clk);
      rst_b = 1;
      chk_val(input0_channel_map, `MAP0_RESET);
      chk_val(input1_channel_map, `MAP1_RESET);
      chk_mode(`MODE_SLEEP);
      pins(1, 2'b00);
      chk_val({7'h0, spi_write_ok}, 8'h01);
      write(8'h20, 8'h04, 8'h08, 1);
      write(8'h00, 8'h04, 8'h08, 1);
      write(8'h00, 8'h04, 8'h08, 0);
      write(8'h00, 8'h00, 8'h00, 0);
      pins(1, 2'b01);
      pins(1, 2'b00);
      spi_pg0 = 1;
      write(8'h00, 8'h04, 8'h08, 0);
      {spi_pg1, spi_pg0} = 2'b10;
      write(8'h00, 8'h04, 8'h08, 0);
      chk_val({6'h0, pulse_gen1_enable, pulse_gen0_enable}, 8'h02);
      spi_pg1 = 0;
      write(8'h20, 8'h04, 8'h08, 0);
      vdd_uv = 1;
      settle;
      vdd_uv = 0;
      write(8'h20, 8'h04, 8'h08, 0);
      chan_fault = 8'h01;
      @(negedge clk);
      chan_fault = 8'h00;
      {uv_raw, lop_raw} = 2'b11;
      host_model_i.pulse(1);
      chk_val({6'h0, analog_undervoltage_flag, digital_low_power_flag}, 8'h00);
      {oe_m, h_m, g_m} = 10'h000;
      settle;
      chk_val(channel_error_bit, 8'h01);
      pins(0, 2'b10);
      chk_val({7'h0, transmission_error_flag}, 8'h01);
      chk_val(channel_error_bit, 8'h01);
      write(8'hFF, 8'h00, 8'h00, 1);
      host_model_i.pulse(0);
      @(negedge clk);
      chk_val({7'h0, transmission_error_flag}, 8'h00);
      pins(1, 2'b10);
      repeat (12) begin
         rnd = lfsr(lfsr(lfsr(rnd)));
         {vs_above_op, vdd_above_lop, uv_raw, lop_raw, ter_raw, open_load_on_flag_raw, open_load_off_flag_raw} = rnd[11:5];
         pins(rnd[0], rnd[2:1]);
      end
      print_verdict;
   end
endmodule // tb_top
`default_nettype wire
